// ==== verilog/cpc_consts.svh ====
// channel power control: offsets, field positions, reset values, timing
// assumes inclusion by the package and the design module only
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define CPC_ADDR_CHANNEL_ENABLE 8'h76
`define CPC_ADDR_DYNAMIC_POWER_CONFIG 8'h77
`define CPC_ADDR_POWER_CONFIG 8'h78
`define CPC_ADDR_CHANNEL_POWER_STATUS 8'h79

// ------------------------------------------------
// reset values and write masks
// ------------------------------------------------
`define CPC_RESET_CHANNEL_ENABLE 8'hcc
`define CPC_RESET_DYNAMIC_POWER_CONFIG 8'h00
`define CPC_RESET_POWER_CONFIG 8'h00
`define CPC_MASK_DYNAMIC_POWER_CONFIG 8'hf8
`define CPC_MASK_POWER_CONFIG 8'hee

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define CPC_BIT_RECORD_DYN_EN 7
`define CPC_BIT_RECORD_RANGE 6
`define CPC_BIT_PLAYBACK_DYN_EN 5
`define CPC_BIT_PLAYBACK_RANGE 4
`define CPC_BIT_SPLIT_CLOCKS 3
`define CPC_BIT_RECORD_ON 7
`define CPC_BIT_PLAYBACK_ON 6
`define CPC_BIT_MIC_BIAS_ON 5
`define CPC_BIT_US_DETECT 3
`define CPC_BIT_VOICE_DETECT 2
`define CPC_BIT_US_ALT 1

// ------------------------------------------------
// timing: channel settle time and its cycle count at 250 MHz
// ------------------------------------------------
`define CPC_SETTLE_NS 100
`define CPC_CLOCK_MHZ 250
`define CPC_SETTLE_CYCLES ((`CPC_SETTLE_NS * `CPC_CLOCK_MHZ + 999) / 1000)

`endif

// ==== verilog/cpc_pkg.sv ====
// channel power control: shared types
// assumes the constants header is present on the include path
package cpc_pkg;
  `include "cpc_consts.svh"

  typedef enum logic [3:0] {
    CPC_OFF = 4'h1,
    CPC_RISING = 4'h2,
    CPC_ON = 4'h4,
    CPC_FALLING = 4'h8
  } cpc_chan_state_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } cpc_reg_req_t;

  typedef struct packed {
    logic [3:0] ctrl_enable;
    logic [3:0] ctrl_dynamic;
    logic [3:0] ctrl_range;
  } cpc_unused_t;

  typedef struct packed {
    logic [7:0] channel_enable;
    logic [7:0] dynamic_power_config;
    logic [7:0] power_config;
    logic [7:0] read_data;
    logic read_valid;
    logic [7:0] powered;
    logic [7:0] target;
    logic [7:0][4:0] timer;
    logic mic_bias_power_on;
    logic [2:0] detect_run;
    logic split_clocks;
  } cpc_state_t;
endpackage

// ==== verilog/cpc_channel_power_control.sv ====
// channel power control: power switches, dynamic mode, channel power status
// assumes a register request port driven by the control-interface decoder on clock_i
`timescale 1ns/1ps

// Behaviour
// - record dynamic off: no switching while recording
// - playback dynamic off: no switching while playing
// - record range picks channels 1-2 or 1-4
// - playback range picks channels 1-2 or 1-4
// - split-clocks bit selects shared or separate clocks
// - record power bit gates enabled input channels
// - playback power bit gates enabled output channels
// - mic bias follows its power bit, reset off
// - ultrasound detect runs only when enabled
// - voice detect runs only when enabled
// - alternate ultrasound runs only when enabled
// - upper status bits show input channel power
// - lower status bits show output channel power
// - per-channel enable gates power-up eligibility of input and output channels
module cpc_channel_power_control
  import cpc_pkg::*;
#(
  parameter logic [4:0] SETTLE_CYCLES = 5'(`CPC_SETTLE_CYCLES)
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register access
  input wire cpc_reg_req_t req_i,
  output logic [7:0] read_data_o,
  output logic read_valid_o,
  // power and algorithm controls
  output logic [7:0] channel_power_o,
  output logic mic_bias_power_on_o,
  output logic ultrasound_detect_o,
  output logic voice_detect_o,
  output logic ultrasound_alt_o,
  output logic dynamic_power_split_clocks_o
);

  cpc_state_t r;
  cpc_state_t next_r;
  logic [1:0] rst_sync;
  logic rst_b;

  assign rst_b = rst_sync[1];

  // ------------------------------------------------
  // reset release
  // ------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ------------------------------------------------
  // next state
  // ------------------------------------------------
  always_comb
  begin
    logic record_active;
    logic playback_active;
    logic [7:0] want;
    logic [7:0] managed;
    next_r = r;
    want = 8'h00;
    managed = 8'h00;
    record_active = |r.powered[7:4];
    playback_active = |r.powered[3:0];
    next_r.read_valid = 1'b0;

    // ------------------------------------------------
    // register writes
    // ------------------------------------------------
    if (req_i.write)
    begin
      case (req_i.addr)
        `CPC_ADDR_CHANNEL_ENABLE: next_r.channel_enable = req_i.data;
        `CPC_ADDR_DYNAMIC_POWER_CONFIG: next_r.dynamic_power_config = req_i.data & `CPC_MASK_DYNAMIC_POWER_CONFIG;
        `CPC_ADDR_POWER_CONFIG: next_r.power_config = req_i.data & `CPC_MASK_POWER_CONFIG;
        default: next_r.power_config = r.power_config;
      endcase
    end

    // ------------------------------------------------
    // register reads
    // ------------------------------------------------
    if (req_i.read)
    begin
      next_r.read_valid = 1'b1;
      case (req_i.addr)
        `CPC_ADDR_CHANNEL_ENABLE: next_r.read_data = r.channel_enable;
        `CPC_ADDR_DYNAMIC_POWER_CONFIG: next_r.read_data = r.dynamic_power_config;
        `CPC_ADDR_POWER_CONFIG: next_r.read_data = r.power_config;
        `CPC_ADDR_CHANNEL_POWER_STATUS: next_r.read_data = r.powered;
        default: next_r.read_data = 8'h00;
      endcase
    end

    // ------------------------------------------------
    // requested channel state
    // ------------------------------------------------
    want[7:4] = r.power_config[`CPC_BIT_RECORD_ON] ? r.channel_enable[7:4] : 4'h0;
    want[3:0] = r.power_config[`CPC_BIT_PLAYBACK_ON] ? r.channel_enable[3:0] : 4'h0;
    // channels that may change individually while the path runs
    managed[7:4] = r.dynamic_power_config[`CPC_BIT_RECORD_RANGE] ? 4'hf : 4'hc;
    managed[3:0] = r.dynamic_power_config[`CPC_BIT_PLAYBACK_RANGE] ? 4'hf : 4'hc;
    if (!r.dynamic_power_config[`CPC_BIT_RECORD_DYN_EN])
    begin
      managed[7:4] = 4'h0;
    end
    if (!r.dynamic_power_config[`CPC_BIT_PLAYBACK_DYN_EN])
    begin
      managed[3:0] = 4'h0;
    end
    // path off always powers all down; otherwise hold unmanaged channels while active
    if (r.power_config[`CPC_BIT_RECORD_ON] && record_active)
    begin
      next_r.target[7:4] = (want[7:4] & managed[7:4]) | (r.target[7:4] & ~managed[7:4]);
    end
    else
    begin
      next_r.target[7:4] = want[7:4];
    end
    if (r.power_config[`CPC_BIT_PLAYBACK_ON] && playback_active)
    begin
      next_r.target[3:0] = (want[3:0] & managed[3:0]) | (r.target[3:0] & ~managed[3:0]);
    end
    else
    begin
      next_r.target[3:0] = want[3:0];
    end

    // ------------------------------------------------
    // per-channel settle timers; status follows completion
    // ------------------------------------------------
    for (int i = 0; i < 8; i++)
    begin
      if (r.target[i] == r.powered[i])
      begin
        next_r.timer[i] = 4'h0;
      end
      else if (r.timer[i] + 5'h1 >= SETTLE_CYCLES)
      begin
        next_r.timer[i] = 4'h0;
        next_r.powered[i] = r.target[i];
      end
      else
      begin
        next_r.timer[i] = r.timer[i] + 5'h1;
      end
    end

    // ------------------------------------------------
    // bias and algorithm controls
    // ------------------------------------------------
    next_r.mic_bias_power_on = r.power_config[`CPC_BIT_MIC_BIAS_ON];
    next_r.detect_run[2] = r.power_config[`CPC_BIT_US_DETECT];
    next_r.detect_run[1] = r.power_config[`CPC_BIT_VOICE_DETECT];
    next_r.detect_run[0] = r.power_config[`CPC_BIT_US_ALT];
    next_r.split_clocks = r.dynamic_power_config[`CPC_BIT_SPLIT_CLOCKS];
  end

  // ------------------------------------------------
  // state registers
  // ------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r.channel_enable <= `CPC_RESET_CHANNEL_ENABLE;
      r.dynamic_power_config <= `CPC_RESET_DYNAMIC_POWER_CONFIG;
      r.power_config <= `CPC_RESET_POWER_CONFIG;
      r.read_data <= 8'h00;
      r.read_valid <= 1'b0;
      r.powered <= 8'h00;
      r.target <= 8'h00;
      r.timer <= '0;
      r.mic_bias_power_on <= 1'b0;
      r.detect_run <= 3'h0;
      r.split_clocks <= 1'b0;
    end
    else
    begin
      r.channel_enable <= next_r.channel_enable;
      r.dynamic_power_config <= next_r.dynamic_power_config;
      r.power_config <= next_r.power_config;
      r.read_data <= next_r.read_data;
      r.read_valid <= next_r.read_valid;
      r.powered <= next_r.powered;
      r.target <= next_r.target;
      r.timer <= next_r.timer;
      r.mic_bias_power_on <= next_r.mic_bias_power_on;
      r.detect_run <= next_r.detect_run;
      r.split_clocks <= next_r.split_clocks;
    end
  end

  // ------------------------------------------------
  // outputs
  // ------------------------------------------------
  assign read_data_o = r.read_data;
  assign read_valid_o = r.read_valid;
  assign channel_power_o = r.powered;
  assign mic_bias_power_on_o = r.mic_bias_power_on;
  assign ultrasound_detect_o = r.detect_run[2];
  assign voice_detect_o = r.detect_run[1];
  assign ultrasound_alt_o = r.detect_run[0];
  assign dynamic_power_split_clocks_o = r.split_clocks;

endmodule

// ==== bench/cpc_monitor.sv ====
// checker: register and power relations at the block ports
// assumes a bind onto the block top
`timescale 1ns/1ps
module cpc_monitor
  import cpc_pkg::*;
#(
  parameter logic [4:0] SETTLE_CYCLES = 5'd2
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // register port
  input wire cpc_reg_req_t req_i,
  input wire logic [7:0] read_data_o,
  input wire logic read_valid_o,
  // power and controls
  input wire logic [7:0] channel_power_o,
  input wire logic mic_bias_power_on_o,
  input wire logic ultrasound_detect_o,
  input wire logic voice_detect_o,
  input wire logic ultrasound_alt_o,
  input wire logic dynamic_power_split_clocks_o
);
  localparam int OFF_DLY = int'(SETTLE_CYCLES) + 6;
  wire logic w77 = req_i.write && req_i.addr == 8'h77;
  wire logic w78 = req_i.write && req_i.addr == 8'h78;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_status_read:
    assert property (req_i.read && req_i.addr == 8'h79 |=> read_data_o == $past(channel_power_o))
    else $error("status read differs from power state");
  a_dyn_reserved:
    assert property (req_i.read && req_i.addr == 8'h77 |=> read_data_o[2:0] == 3'h0)
    else $error("dynamic config reserved bits nonzero");
  a_pwr_reserved:
    assert property (req_i.read && req_i.addr == 8'h78 |=> !read_data_o[4] && !read_data_o[0])
    else $error("power config reserved bits nonzero");
  a_mic_bias:
    assert property (w78 |=> ##1 mic_bias_power_on_o == $past(req_i.data[5], 2))
    else $error("mic bias does not follow its bit");
  a_us_detect:
    assert property (w78 |=> ##1 ultrasound_detect_o == $past(req_i.data[3], 2))
    else $error("ultrasound detect does not follow its bit");
  a_voice_detect:
    assert property (w78 |=> ##1 voice_detect_o == $past(req_i.data[2], 2))
    else $error("voice detect does not follow its bit");
  a_us_alt:
    assert property (w78 |=> ##1 ultrasound_alt_o == $past(req_i.data[1], 2))
    else $error("alternate ultrasound does not follow its bit");
  a_split_clocks:
    assert property (w77 |=> ##1 dynamic_power_split_clocks_o == $past(req_i.data[3], 2))
    else $error("split clocks does not follow its bit");
  a_record_off:
    assert property (w78 && !req_i.data[7] |-> ##OFF_DLY channel_power_o[7:4] == 4'h0)
    else $error("inputs still powered after record off");
  a_playback_off:
    assert property (w78 && !req_i.data[6] |-> ##OFF_DLY channel_power_o[3:0] == 4'h0)
    else $error("outputs still powered after playback off");
endmodule

bind cpc_channel_power_control cpc_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_monitor (.clock_i, .rst_b_i,
  .req_i, .read_data_o, .read_valid_o, .channel_power_o, .mic_bias_power_on_o, .ultrasound_detect_o,
  .voice_detect_o, .ultrasound_alt_o, .dynamic_power_split_clocks_o);

// ==== bench/channel_power_control_tb_top.sv ====
// testbench: random register traffic against a channel power model
// assumes package, block and checker compiled first
`timescale 1ns/1ps
module channel_power_control_tb_top
  import cpc_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  cpc_reg_req_t req_i = '0;
  logic [7:0] rdat, cp, pw = 8'h00, d = 8'h00, e = 8'hcc, p = 8'h00;
  logic rv, mb, ud, vd, ua, sc;
  int num_errors = 0;
  int checks = 0;
  always #2 clock_i = ~clock_i;
  cpc_channel_power_control #(.SETTLE_CYCLES(5'd2)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .read_data_o(rdat), .read_valid_o(rv), .channel_power_o(cp), .mic_bias_power_on_o(mb),
    .ultrasound_detect_o(ud), .voice_detect_o(vd), .ultrasound_alt_o(ua), .dynamic_power_split_clocks_o(sc));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clock_i);
    req_i = {1'b1, 1'b0, a, v};
    @(negedge clock_i);
    req_i = '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clock_i);
    req_i = {1'b0, 1'b1, a, 8'h00};
    @(negedge clock_i);
    req_i = '0;
    chk("valid", 8'h01, {7'h0, rv});
    chk("read", exp, rdat);
  endtask
  // one path: managed channels follow enables, others hold while powered
  function automatic logic [3:0] pth(logic on, logic [3:0] mm, logic [3:0] en, logic [3:0] cur);
    logic [3:0] r;
    r = (en & mm) | (cur & ~mm);
    if (cur == 4'h0 || r == 4'h0)
      r = en;
    return on ? r : 4'h0;
  endfunction
  // one write, then the model moves on, the design settles and is compared
  task automatic step(logic [7:0] a, logic [7:0] v);
    wr(a, v);
    pw = {pth(p[7], d[7] ? (d[6] ? 4'hf : 4'hc) : 4'h0, e[7:4], pw[7:4]),
          pth(p[6], d[5] ? (d[4] ? 4'hf : 4'hc) : 4'h0, e[3:0], pw[3:0])};
    repeat (16) @(negedge clock_i);
    chk("power", pw, cp);
  endtask
  task automatic test_done();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    num_errors++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h41927a0a));
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    rd(8'h76, 8'hcc);
    rd(8'h77, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h00);
    wr(8'h5a, 8'hff);
    rd(8'h5a, 8'h00);
    for (int i = 0; i < 60; i++)
    begin
      d = 8'($urandom) & 8'hf8;
      step(8'h77, d);
      e = 8'($urandom);
      step(8'h76, e);
      p = 8'($urandom) & 8'hee;
      step(8'h78, p);
      wr(8'h79, ~pw);
      rd(8'h76, e);
      rd(8'h79, pw);
      rd(8'h77, d & 8'hf8);
      rd(8'h78, p & 8'hee);
      chk("controls", {3'h0, p[5], p[3], p[2], p[1], d[3]}, {3'h0, mb, ud, vd, ua, sc});
    end
    test_done();
  end
endmodule
